// ===== common/die_temp_pkg.sv
// die_temp_pkg: shared constants for the die temperature readout, source
// select, threshold alarm and open-loop compensation block.
// assumes byte-wide registers, one per aligned 32-bit APB word.
package die_temp_pkg;

  // ****************************************
  // data formats
  // ****************************************
  localparam int TEMP_W = 16;        // signed, degrees C scaled by 2^-7
  localparam int TEMP_FRAC = 7;
  localparam int AVG_LOG2 = 12;      // log2 of samples per averaged result
  localparam int COEF_N = 6;         // constant plus five powers
  localparam int COEF_W = 16;
  localparam int COEF_SHIFT = 8;     // coefficient lsb is 2^-23
  localparam int FACTOR_W = 32;      // compensation factor, lsb 2^-31
  localparam int FACTOR_FRAC = 31;
  localparam int TW_W = 32;          // tuning word width
  localparam int NUM_TARGETS = 4;    // oscillators/converters corrected
  localparam int IDX_W = 14;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_EXT_LO = 14'h2900;
  localparam logic [IDX_W-1:0] IDX_EXT_HI = 14'h2901;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL = 14'h2902;
  localparam logic [IDX_W-1:0] IDX_LOW_LO = 14'h2903;
  localparam logic [IDX_W-1:0] IDX_LOW_HI = 14'h2904;
  localparam logic [IDX_W-1:0] IDX_HIGH_LO = 14'h2905;
  localparam logic [IDX_W-1:0] IDX_HIGH_HI = 14'h2906;
  localparam logic [IDX_W-1:0] IDX_APPLY = 14'h2907;
  localparam logic [IDX_W-1:0] IDX_COEF_BASE = 14'h2908;
  localparam logic [IDX_W-1:0] IDX_LIVE = 14'h3002;
  localparam logic [IDX_W-1:0] IDX_DIE_LO = 14'h3003;
  localparam logic [IDX_W-1:0] IDX_DIE_HI = 14'h3004;
  localparam logic [IDX_W-1:0] IDX_EVENT = 14'h300C;
  localparam logic [IDX_W-1:0] IDX_MASK = 14'h300D;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SEL_SYS = 0;
  localparam int SEL_LOOP0 = 1;
  localparam int SEL_LOOP1 = 2;
  localparam int ALARM_BIT = 0;
  localparam int WARN_BIT = 4;
  localparam logic [2:0] SRC_SEL_RESET = 3'h0;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 16'h0000;
  localparam logic [TEMP_W-1:0] HIGH_RESET = 16'h7FFF;
  localparam logic [TEMP_W-1:0] LOW_RESET = 16'h8000;

  typedef enum logic [0:0] {POLY_IDLE, POLY_STEP} poly_state_t;

endpackage

// ===== src/temp_averager.sv
// temp_averager: sums 2^AVG_LOG2 converter samples, emits their mean.
// assumes samples arrive on clk with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none
module temp_averager
  import die_temp_pkg::*;
#(
  parameter int SAMPLE_W = die_temp_pkg::TEMP_W,
  parameter int LOG2_N = die_temp_pkg::AVG_LOG2
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] sampleData,
  output logic resultValid,
  output logic [SAMPLE_W-1:0] resultData
);
  import die_temp_pkg::*;

  typedef struct packed {
    logic [LOG2_N-1:0] count;
    logic signed [SAMPLE_W+LOG2_N-1:0] sum;
    logic valid;
    logic [SAMPLE_W-1:0] mean;
  } avg_state_t;

  avg_state_t s;
  avg_state_t next_s;
  logic signed [SAMPLE_W+LOG2_N-1:0] total;

  // ****************************************
  // accumulate and dump
  // ****************************************
  // sum is wide enough that no run of samples can overflow it
  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    total = s.sum + (SAMPLE_W+LOG2_N)'($signed(sampleData));
    if (sampleValid)
    begin
      next_s.count = s.count + 1'b1;
      if (&s.count)
      begin
        next_s.sum = '0;
        next_s.valid = 1'b1;
        next_s.mean = total[SAMPLE_W+LOG2_N-1:LOG2_N];
      end
      else
      begin
        next_s.sum = total;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign resultValid = s.valid;
  assign resultData = s.mean;
endmodule // temp_averager
`default_nettype wire

// ===== src/die_temp_monitor.sv
// die_temp_monitor: die sensor readout, per-consumer source select,
// threshold alarm with warning interrupt, and open-loop compensation.
// assumes an APB4 master on clk and a sensor converter on the same clock.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - three consumers take sensor or external temperature
// - three select bits, low bits of select register
// - select zero picks sensor, one picks external
// - die reading readable, sixteen bits, read only
// - temperatures are signed, scaled two to minus seven
// - average 4096 samples per reported result
// - compare each result with high, low limits
// - alarm bit live while result outside limits
// - alarm raises sticky warning event for interrupt
// - external value written raw, no device scaling
// - compensation works on fractional frequency error
// - rate scaled by one plus negated error
// - fifth order polynomial predicts source error
// - zero coefficient drops its power of temperature
// - correction applied only to designated targets
// - system compensation temperature follows its select bit
module die_temp_monitor
  import die_temp_pkg::*;
#(
  parameter int TARGETS = die_temp_pkg::NUM_TARGETS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [die_temp_pkg::ADDR_W-1:0] paddr,
  input wire logic [die_temp_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [die_temp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleValid,
  input wire logic [die_temp_pkg::TEMP_W-1:0] sampleData,
  input wire logic [TARGETS*die_temp_pkg::TW_W-1:0] tuningWordIn,
  output logic [TARGETS*die_temp_pkg::TW_W-1:0] tuningWordOut,
  output logic [die_temp_pkg::TEMP_W-1:0] systemClockTemp,
  output logic [die_temp_pkg::TEMP_W-1:0] loopZeroTemp,
  output logic [die_temp_pkg::TEMP_W-1:0] loopOneTemp,
  output logic [die_temp_pkg::FACTOR_W-1:0] compensationFactor,
  output logic tempAlarm,
  output logic irq
);
  import die_temp_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [TEMP_W-1:0] extTemp;
    logic [2:0] srcSel;
    logic [TEMP_W-1:0] lowLimit;
    logic [TEMP_W-1:0] highLimit;
    logic [TARGETS-1:0] apply;
    logic [COEF_N-1:0][COEF_W-1:0] coef;
    logic [TEMP_W-1:0] dieTemp;
    logic alarm;
    logic alarmPrev;
    logic warnEvent;
    logic warnMask;
    logic irq;
    logic [TEMP_W-1:0] sysTemp;
    logic [TEMP_W-1:0] loop0Temp;
    logic [TEMP_W-1:0] loop1Temp;
    poly_state_t poly;
    logic [2:0] step;
    logic signed [FACTOR_W-1:0] acc;
    logic [TEMP_W-1:0] polyTemp;
    logic recalc;
    logic [FACTOR_W-1:0] factor;
    logic [TARGETS-1:0][TW_W-1:0] tuned;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } mon_state_t;

  localparam logic [2:0] TOP_POWER = 3'(COEF_N - 1);
  localparam int PROD_W = FACTOR_W + TEMP_W;
  localparam int SCALE_W = TW_W + 1 + FACTOR_W;

  mon_state_t s;
  mon_state_t next_s;
  logic avgValid;
  logic [TEMP_W-1:0] avgValue;
  logic [DATA_W-1:0] readData;
  logic addrHit;
  logic [IDX_W-1:0] idx;
  logic access;
  logic done;
  logic coefWrite;
  logic [2:0] coefSlot;
  logic [IDX_W-1:0] coefOff;
  logic signed [PROD_W-1:0] prod;
  logic signed [FACTOR_W-1:0] coefExt;
  logic [TARGETS-1:0][TW_W-1:0] scaled;

  // ****************************************
  // sensor averaging
  // ****************************************
  temp_averager #(
    .SAMPLE_W(TEMP_W),
    .LOG2_N(AVG_LOG2)
  ) u_avg (
    .clk(clk),
    .rst_n(rst_n),
    .sampleValid(sampleValid),
    .sampleData(sampleData),
    .resultValid(avgValid),
    .resultData(avgValue)
  );

  // ****************************************
  // per-target rate correction
  // ****************************************
  // rate times (1 + factor); undesignated targets pass straight through
  generate
    for (genvar t = 0; t < TARGETS; t++)
    begin : g_target
      logic signed [SCALE_W-1:0] delta;
      assign delta = $signed({1'b0, tuningWordIn[t*TW_W +: TW_W]})
        * $signed(s.factor);
      assign scaled[t] = s.apply[t]
        ? tuningWordIn[t*TW_W +: TW_W]
          + delta[FACTOR_FRAC +: TW_W]
        : tuningWordIn[t*TW_W +: TW_W];
    end
  endgenerate

  // ****************************************
  // address decode and read mux
  // ****************************************
  // byte registers; a 16-bit field spans two indices, low byte first
  assign idx = paddr[ADDR_W-1:2];
  assign coefOff = idx - IDX_COEF_BASE;
  assign coefSlot = coefOff[3:1];

  always_comb
  begin
    readData = '0;
    addrHit = 1'b1;
    if (paddr[1:0] != 2'b00)
      addrHit = 1'b0;
    else if (idx >= IDX_COEF_BASE
      && coefOff < IDX_W'(2 * COEF_N))
      readData[7:0] = coefOff[0] ? s.coef[coefSlot][15:8]
                                 : s.coef[coefSlot][7:0];
    else
    begin
      unique case (idx)
        IDX_EXT_LO: readData[7:0] = s.extTemp[7:0];
        IDX_EXT_HI: readData[7:0] = s.extTemp[15:8];
        IDX_SRC_SEL: readData[2:0] = s.srcSel;
        IDX_LOW_LO: readData[7:0] = s.lowLimit[7:0];
        IDX_LOW_HI: readData[7:0] = s.lowLimit[15:8];
        IDX_HIGH_LO: readData[7:0] = s.highLimit[7:0];
        IDX_HIGH_HI: readData[7:0] = s.highLimit[15:8];
        IDX_APPLY: readData[TARGETS-1:0] = s.apply;
        IDX_LIVE: readData[ALARM_BIT] = s.alarm;
        IDX_DIE_LO: readData[7:0] = s.dieTemp[7:0];
        IDX_DIE_HI: readData[7:0] = s.dieTemp[15:8];
        IDX_EVENT: readData[WARN_BIT] = s.warnEvent;
        IDX_MASK: readData[WARN_BIT] = s.warnMask;
        default: addrHit = 1'b0;
      endcase
    end
  end

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    next_s = s;
    access = psel & penable;
    done = access & s.pready;
    // the coefficient window is bounded above as well, or every status
    // or mask index beyond it would land in a coefficient slot
    coefWrite = done & pwrite & pstrb[0] & addrHit
      & (idx >= IDX_COEF_BASE)
      & (coefOff < IDX_W'(2 * COEF_N));

    // one wait state: data is captured in the first access cycle
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0; // error flag only stands beside pready
    if (access && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.prdata = readData;
      next_s.pslverr = ~addrHit;
    end

    // writes land only at the edge where pready is seen high
    if (done && pwrite && pstrb[0] && addrHit)
    begin
      if (coefWrite)
      begin
        if (coefOff[0])
          next_s.coef[coefSlot][15:8] = pwdata[7:0];
        else
          next_s.coef[coefSlot][7:0] = pwdata[7:0];
        next_s.recalc = 1'b1;
      end
      else
      begin
        unique case (idx)
          IDX_EXT_LO: next_s.extTemp[7:0] = pwdata[7:0];
          IDX_EXT_HI: next_s.extTemp[15:8] = pwdata[7:0];
          IDX_SRC_SEL: next_s.srcSel = pwdata[2:0];
          IDX_LOW_LO: next_s.lowLimit[7:0] = pwdata[7:0];
          IDX_LOW_HI: next_s.lowLimit[15:8] = pwdata[7:0];
          IDX_HIGH_LO: next_s.highLimit[7:0] = pwdata[7:0];
          IDX_HIGH_HI: next_s.highLimit[15:8] = pwdata[7:0];
          IDX_APPLY: next_s.apply = pwdata[TARGETS-1:0];
          IDX_MASK: next_s.warnMask = pwdata[WARN_BIT];
          default: next_s.apply = s.apply; // read-only targets
        endcase
      end
    end

    // whole 16-bit result replaced at once, never byte by byte
    if (avgValid)
      next_s.dieTemp = avgValue;

    // live comparison against the latest result, signed
    next_s.alarm = ($signed(s.dieTemp) > $signed(s.highLimit))
      || ($signed(s.dieTemp) < $signed(s.lowLimit));
    next_s.alarmPrev = s.alarm;

    // read clears the event, but a new crossing in that cycle wins
    if (done && !pwrite && addrHit && idx == IDX_EVENT)
      next_s.warnEvent = 1'b0;
    if (s.alarm && !s.alarmPrev)
      next_s.warnEvent = 1'b1;
    next_s.irq = next_s.warnEvent & next_s.warnMask;

    // consumer routing: select bit low means the die sensor
    next_s.sysTemp = s.srcSel[SEL_SYS] ? s.extTemp
                                       : s.dieTemp;
    next_s.loop0Temp = s.srcSel[SEL_LOOP0] ? s.extTemp
                                           : s.dieTemp;
    next_s.loop1Temp = s.srcSel[SEL_LOOP1] ? s.extTemp
                                           : s.dieTemp;

    // horner evaluation, one power per cycle; the model yields the
    // source's fractional frequency error (a fit made on period
    // error must be converted first: ffe = -fpe / (fpe + 1))
    coefExt = FACTOR_W'(signed'(s.coef[s.step])) <<< COEF_SHIFT;
    prod = $signed(s.acc) * $signed(s.polyTemp);
    unique case (s.poly)
      POLY_IDLE:
      begin
        if (s.recalc || s.polyTemp != s.sysTemp)
        begin
          next_s.recalc = 1'b0;
          next_s.polyTemp = s.sysTemp;
          next_s.acc = FACTOR_W'(signed'(s.coef[TOP_POWER]))
            <<< COEF_SHIFT;
          next_s.step = TOP_POWER - 3'd1;
          next_s.poly = POLY_STEP;
        end
      end
      POLY_STEP:
      begin
        // a zero coefficient adds nothing, dropping its power
        next_s.acc = FACTOR_W'(prod >>> TEMP_FRAC) + coefExt;
        if (s.step == 3'd0)
        begin
          next_s.poly = POLY_IDLE;
          next_s.factor = FACTOR_W'(-(FACTOR_W'(prod >>> TEMP_FRAC)
            + coefExt));
        end
        else
        begin
          next_s.step = s.step - 3'd1;
        end
      end
    endcase

    next_s.tuned = scaled;
  end

  // ****************************************
  // state register
  // ****************************************
  // limits reset wide open so no alarm fires before software sets them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.srcSel <= SRC_SEL_RESET;
      s.extTemp <= TEMP_RESET;
      s.highLimit <= HIGH_RESET;
      s.lowLimit <= LOW_RESET;
      s.poly <= POLY_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs, all straight from the state register
  // ****************************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign tuningWordOut = s.tuned;
  assign systemClockTemp = s.sysTemp;
  assign loopZeroTemp = s.loop0Temp;
  assign loopOneTemp = s.loop1Temp;
  assign compensationFactor = s.factor;
  assign tempAlarm = s.alarm;
  assign irq = s.irq;
endmodule // die_temp_monitor
`default_nettype wire

// ===== verification/die_temp_monitor_chk.sv
// die_temp_monitor_chk: port-level checks of the die temperature block.
// assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module die_temp_monitor_chk
  import die_temp_pkg::*;
#(
  parameter int TARGETS = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [die_temp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sampleValid,
  input wire logic [TARGETS*die_temp_pkg::TW_W-1:0] tuningWordIn,
  input wire logic [TARGETS*die_temp_pkg::TW_W-1:0] tuningWordOut,
  input wire logic [die_temp_pkg::TEMP_W-1:0] systemClockTemp,
  input wire logic [die_temp_pkg::TEMP_W-1:0] loopZeroTemp,
  input wire logic [die_temp_pkg::TEMP_W-1:0] loopOneTemp,
  input wire logic [die_temp_pkg::FACTOR_W-1:0] compensationFactor,
  input wire logic tempAlarm,
  input wire logic irq
);
  // ****************************************
  // helper: cycles since anything could move a derived output
  // ****************************************
  logic [3:0] calm;
  // saturates so a quiet bench never wraps into a false cause
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      calm <= 4'hF;
    else if (sampleValid || (pready && pwrite) || $changed(systemClockTemp))
      calm <= 4'h0;
    else if (calm != 4'hF)
      calm <= calm + 4'h1;
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  property p_apb_wait;
    s_setup |=> s_answer;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not in second access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_rd_upper;
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  property p_irq_fall;
    $fell(irq) |-> $past(pready) || $past(pready, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a register access");
  property p_alarm_cause;
    $changed(tempAlarm) |-> calm < 4'h6;
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm moved without a new result or limit");
  property p_temp_cause;
    $changed(loopZeroTemp) || $changed(loopOneTemp)
      || $changed(systemClockTemp) |-> calm < 4'h6;
  endproperty
  a_temp_cause: assert property (p_temp_cause)
    else $error("consumer temperature moved without cause");
  property p_factor_cause;
    $changed(compensationFactor) |-> calm != 4'hF;
  endproperty
  a_factor_cause: assert property (p_factor_cause)
    else $error("factor moved without temperature or write");
  property p_tw_pass;
    compensationFactor == 32'h0000_0000 [*3]
      |-> tuningWordOut == $past(tuningWordIn);
  endproperty
  a_tw_pass: assert property (p_tw_pass)
    else $error("tuning word altered with zero factor");
endmodule // die_temp_monitor_chk

bind die_temp_monitor die_temp_monitor_chk #(.TARGETS(TARGETS)) u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleValid(sampleValid), .tuningWordIn(tuningWordIn),
  .tuningWordOut(tuningWordOut), .systemClockTemp(systemClockTemp),
  .loopZeroTemp(loopZeroTemp), .loopOneTemp(loopOneTemp),
  .compensationFactor(compensationFactor), .tempAlarm(tempAlarm),
  .irq(irq));
`default_nettype wire

// ===== verification/testbench.sv
// testbench: register-level tests of the die temperature block over APB.
// assumes the package and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import die_temp_pkg::*;
  // ****************************************
  // signals and design
  // ****************************************
  logic clk, rst_n, psel, penable, pwrite, sampleValid, pready, pslverr;
  logic tempAlarm, irq, er;
  logic [15:0] paddr, sampleData, sysT, l0T, l1T;
  logic [31:0] pwdata, prdata, rd, factor;
  logic [3:0] pstrb;
  logic [NUM_TARGETS*TW_W-1:0] twIn, twOut;
  int err_total = 0;
  int comparisons = 0;
  die_temp_monitor DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .sampleData(sampleData),
    .tuningWordIn(twIn), .tuningWordOut(twOut), .systemClockTemp(sysT),
    .loopZeroTemp(l0T), .loopOneTemp(l1T), .compensationFactor(factor),
    .tempAlarm(tempAlarm), .irq(irq));
  // 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; answer and read data taken at the edge pready is seen
  task automatic apb(input logic [13:0] idx, input logic w,
    input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a hung transfer
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    chk_word({31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rdchk(input logic [13:0] idx, input logic [7:0] e,
    input logic ee);
    apb(idx, 1'b0, 8'h00);
    chk_word(rd, {24'h00_0000, e});
    chk_word({31'h0, er}, {31'h0, ee});
  endtask
  // low byte at the lower index
  task automatic wr16(input logic [13:0] idx, input logic [15:0] d);
    wr(idx, d[7:0]);
    wr(idx + 14'h1, d[15:8]);
  endtask
  // one full average of a constant sample
  task automatic feed(input logic [15:0] v);
    repeat (1 << AVG_LOG2)
    begin
      @(posedge clk);
      sampleValid <= 1'b1;
      sampleData <= v;
    end
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic test_done;
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    sampleValid = 1'b0;
    sampleData = 16'h0000;
    twIn = {NUM_TARGETS{32'h4000_0000}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(IDX_SRC_SEL, 8'h00, 1'b0);
    rdchk(IDX_HIGH_HI, 8'h7F, 1'b0);
    rdchk(IDX_LOW_HI, 8'h80, 1'b0);
    rdchk(14'h1000, 8'h00, 1'b1);
    wr(IDX_DIE_LO, 8'h55);
    feed(16'h118D);
    rdchk(IDX_DIE_LO, 8'h8D, 1'b0);
    rdchk(IDX_DIE_HI, 8'h11, 1'b0);
    // every select combination routes each consumer on its own
    wr16(IDX_EXT_LO, 16'h2F80);
    for (int s = 0; s < 8; s++)
    begin
      wr(IDX_SRC_SEL, 8'(s));
      repeat (3) @(posedge clk);
      chk_word({16'h0, sysT}, {16'h0, s[0] ? 16'h2F80 : 16'h118D});
      chk_word({16'h0, l0T}, {16'h0, s[1] ? 16'h2F80 : 16'h118D});
      chk_word({16'h0, l1T}, {16'h0, s[2] ? 16'h2F80 : 16'h118D});
    end
    wr(IDX_MASK, 8'h10);
    wr16(IDX_HIGH_LO, 16'h118D);
    // let the new limit reach the comparator before looking
    repeat (3) @(posedge clk);
    chk_word({31'h0, tempAlarm}, 32'h0000_0000);
    wr(IDX_HIGH_LO, 8'h8C);
    repeat (4) @(posedge clk);
    chk_word({31'h0, irq}, 32'h0000_0001);
    rdchk(IDX_LIVE, 8'h01, 1'b0);
    rdchk(IDX_EVENT, 8'h10, 1'b0);
    rdchk(IDX_EVENT, 8'h00, 1'b0);
    wr(IDX_HIGH_LO, 8'hFF);
    wr(IDX_MASK, 8'h00);
    rdchk(IDX_LIVE, 8'h00, 1'b0);
    // negative result against a positive high limit: signed compare
    feed(16'hF833);
    wr16(IDX_HIGH_LO, 16'h0100);
    rdchk(IDX_LIVE, 8'h00, 1'b0);
    wr16(IDX_LOW_LO, 16'hF834);
    rdchk(IDX_LIVE, 8'h01, 1'b0);
    chk_word({31'h0, irq}, 32'h0000_0000);
    rdchk(IDX_EVENT, 8'h10, 1'b0);
    // polynomial at 1.0 and 2.0 degrees, coefficients of 2^-15
    wr(IDX_SRC_SEL, 8'h01);
    wr(IDX_APPLY, 8'h05);
    wr16(IDX_EXT_LO, 16'h0080);
    for (int k = 0; k < 6; k++)
      wr16(IDX_COEF_BASE + 14'(2 * k), 16'h0100);
    repeat (20) @(posedge clk);
    chk_word(factor, 32'hFFFA_0000);
    chk_word(twOut[31:0], 32'h3FFD_0000);
    chk_word(twOut[63:32], 32'h4000_0000);
    for (int k = 3; k < 6; k++)
      wr16(IDX_COEF_BASE + 14'(2 * k), 16'h0000);
    repeat (20) @(posedge clk);
    chk_word(factor, 32'hFFFD_0000);
    wr16(IDX_EXT_LO, 16'h0100);
    repeat (20) @(posedge clk);
    chk_word(factor, 32'hFFF9_0000);
    test_done;
  end
  // watchdog, well beyond the expected run of about 8.5k cycles
  initial
  begin
    #1_000_000;
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done;
  end
endmodule // testbench
`default_nettype wire
